/* rtl/ipl_pkg.sv */
// constants shared by the priority-level register slice
package ipl_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int REG_W = 16;
	// register index; byte address is four times the index
	localparam logic [5:0] IDX_TMR_DEC0 = 6'h06;
	localparam logic [5:0] IDX_TMR_ABC = 6'h07;
	localparam logic [5:0] IDX_SER0_TMRA = 6'h08;
	localparam logic [5:0] IDX_PWM_CONV = 6'h09;

	// ------------------------------------------------------------
	// field layout and reset values
	// ------------------------------------------------------------
	localparam int NSRC = 25;
	localparam int CODE_W = 2;
	localparam int DEC0_W = 4;
	localparam logic [15:0] MASK_TMR_DEC0 = 16'h000f;
	localparam logic [15:0] MASK_SER0_TMRA = 16'hf3ff;
	localparam logic [15:0] MASK_FULL = 16'hffff;
	localparam logic [3:0] RST_TMR_DEC0 = 4'h0;
	localparam logic [15:0] RST_TMR_ABC = 16'h0000;
	localparam logic [15:0] RST_SER0_TMRA = 16'h0000;
	localparam logic [15:0] RST_PWM_CONV = 16'h0000;

	// ------------------------------------------------------------
	// priority codes
	// ------------------------------------------------------------
	localparam logic [1:0] CODE_OFF = 2'h0;
	localparam logic [1:0] CODE_LVL0 = 2'h1;
	localparam logic [1:0] CODE_LVL1 = 2'h2;
	localparam logic [1:0] CODE_LVL2 = 2'h3;

endpackage

/* rtl/ipl_dec_if.sv */
// carrier between the register file and the level decoder
`timescale 1ns/100ps
interface ipl_dec_if;
	import ipl_pkg::*;
	logic [NSRC*CODE_W-1:0] code;
	logic [NSRC-1:0] req;
	logic [NSRC-1:0] en;
	logic [NSRC-1:0] lvl0;
	logic [NSRC-1:0] lvl1;
	logic [NSRC-1:0] lvl2;

	modport regs (
		output code,
		output req,
		input en,
		input lvl0,
		input lvl1,
		input lvl2
	);

	modport dec (
		input code,
		input req,
		output en,
		output lvl0,
		output lvl1,
		output lvl2
	);
endinterface

/* rtl/ipl_decode.sv */
// per-source decode of 2-bit priority codes into level requests
`timescale 1ns/100ps
module ipl_decode
	import ipl_pkg::*;
(
	ipl_dec_if.dec dif
);

	// ------------------------------------------------------------
	// one decoder per source
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < NSRC; i++) begin : g_src
			logic [1:0] c;
			assign c = dif.code[i*CODE_W +: CODE_W];
			// disabled code never reaches the arbiter
			assign dif.en[i] = (c != CODE_OFF);
			// only three levels exist; no code yields more
			assign dif.lvl0[i] = dif.req[i] & (c == CODE_LVL0);
			assign dif.lvl1[i] = dif.req[i] & (c == CODE_LVL1);
			assign dif.lvl2[i] = dif.req[i] & (c == CODE_LVL2);
		end
	endgenerate

endmodule // ipl_decode

/* rtl/ipl_regs.sv */
// priority-level register slice with wishbone slave and level outputs
`timescale 1ns/100ps

module ipl_regs
	import ipl_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	output logic [DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// peripheral requests, bit order as the source list
	input wire logic [NSRC-1:0] src_req_i,
	// toward the arbitration logic
	output logic [NSRC-1:0] src_en_o,
	output logic [NSRC-1:0] lvl0_req_o,
	output logic [NSRC-1:0] lvl1_req_o,
	output logic [NSRC-1:0] lvl2_req_o,
	output logic [2:0] lvl_any_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DEC0_W-1:0] tmr_dec0;
		logic [REG_W-1:0] tmr_abc;
		logic [REG_W-1:0] ser0_tmra;
		logic [REG_W-1:0] pwm_conv;
		logic ack;
		logic [REG_W-1:0] rdat;
		logic [NSRC-1:0] en;
		logic [NSRC-1:0] l0;
		logic [NSRC-1:0] l1;
		logic [NSRC-1:0] l2;
		logic [2:0] any;
	} ipl_state_s;

	ipl_state_s q_reg;
	ipl_state_s q_next;

	ipl_dec_if dif ();

	logic hit;
	logic aligned;
	logic [5:0] idx;
	logic [REG_W-1:0] rd_mux;
	logic [REG_W-1:0] dec0_merged;

	// ------------------------------------------------------------
	// source code vector
	// ------------------------------------------------------------
	// order low-first: decoder, timers, serial/timer A, pwm/conv
	assign dif.code = {
		q_reg.pwm_conv,
		q_reg.ser0_tmra[15:12],
		q_reg.ser0_tmra[9:0],
		q_reg.tmr_abc,
		q_reg.tmr_dec0
	};
	assign dif.req = src_req_i;

	ipl_decode u_decode (
		.dif(dif)
	);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// a strobe is taken once; the ack cycle masks the held request
	assign hit = wb_cyc_i & wb_stb_i & ~q_reg.ack;
	assign aligned = (wb_adr_i[1:0] == 2'h0);
	assign idx = wb_adr_i[ADR_W-1:2];

	// reserved and unmapped bits read zero
	always_comb begin
		rd_mux = '0;
		if (aligned) begin
			case (idx)
				IDX_TMR_DEC0: rd_mux = {12'h000, q_reg.tmr_dec0};
				IDX_TMR_ABC: rd_mux = q_reg.tmr_abc;
				IDX_SER0_TMRA: rd_mux = q_reg.ser0_tmra & MASK_SER0_TMRA;
				IDX_PWM_CONV: rd_mux = q_reg.pwm_conv;
				default: rd_mux = '0;
			endcase
		end
	end

	// byte-lane merge of a write, then strip unimplemented bits
	function automatic logic [REG_W-1:0] merge(
		input logic [REG_W-1:0] old,
		input logic [DAT_W-1:0] wd,
		input logic [SEL_W-1:0] sel,
		input logic [REG_W-1:0] mask
	);
		logic [REG_W-1:0] v;
		v = old;
		if (sel[0]) begin
			v[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			v[15:8] = wd[15:8];
		end
		return v & mask;
	endfunction

	// merged apart so only its low nibble is kept in the state
	assign dec0_merged = merge({12'h000, q_reg.tmr_dec0}, wb_dat_i,
		wb_sel_i, MASK_TMR_DEC0);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		q_next = q_reg;
		q_next.ack = 1'b0;
		if (hit) begin
			q_next.ack = 1'b1;
			// reads only capture; nothing else moves
			q_next.rdat = wb_we_i ? '0 : rd_mux;
			if (wb_we_i && aligned) begin
				case (idx)
					IDX_TMR_DEC0: begin
						q_next.tmr_dec0 = dec0_merged[DEC0_W-1:0];
					end
					IDX_TMR_ABC: begin
						q_next.tmr_abc = merge(q_reg.tmr_abc, wb_dat_i,
							wb_sel_i, MASK_FULL);
					end
					IDX_SER0_TMRA: begin
						// bits 11-10 stay zero whatever is written
						q_next.ser0_tmra = merge(q_reg.ser0_tmra, wb_dat_i,
							wb_sel_i, MASK_SER0_TMRA);
					end
					IDX_PWM_CONV: begin
						q_next.pwm_conv = merge(q_reg.pwm_conv, wb_dat_i,
							wb_sel_i, MASK_FULL);
					end
					default: begin
						// unmapped: acked, write dropped
						q_next.rdat = '0;
					end
				endcase
			end
		end
		// one register stage so outputs leave straight from flops
		q_next.en = dif.en;
		q_next.l0 = dif.lvl0;
		q_next.l1 = dif.lvl1;
		q_next.l2 = dif.lvl2;
		q_next.any = {|dif.lvl2, |dif.lvl1, |dif.lvl0};
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= '0;
			q_reg.tmr_dec0 <= RST_TMR_DEC0;
			q_reg.tmr_abc <= RST_TMR_ABC;
			q_reg.ser0_tmra <= RST_SER0_TMRA;
			q_reg.pwm_conv <= RST_PWM_CONV;
		end else begin
			q_reg <= q_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign wb_ack_o = q_reg.ack;
	assign wb_dat_o = {16'h0000, q_reg.rdat};
	assign src_en_o = q_reg.en;
	assign lvl0_req_o = q_reg.l0;
	assign lvl1_req_o = q_reg.l1;
	assign lvl2_req_o = q_reg.l2;
	assign lvl_any_o = q_reg.any;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_take;
		hit;
	endsequence

	sequence s_wr(logic [5:0] i);
		hit && wb_we_i && aligned && idx == i;
	endsequence

	sequence s_rd(logic [5:0] i);
		hit && !wb_we_i && aligned && idx == i;
	endsequence

	a_ack_answers: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	a_ack_needs_req: assert property (
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");

	a_reset_clear: assert property (
		$past(rst_i) |-> (q_reg.tmr_dec0 == '0 && q_reg.tmr_abc == '0
			&& q_reg.ser0_tmra == '0 && q_reg.pwm_conv == '0))
		else $error("fields not zero after reset");

	a_rsvd_read: assert property (
		s_rd(IDX_SER0_TMRA) |=> wb_dat_o[11:10] == 2'h0
			&& wb_dat_o[15:12] == $past(q_reg.ser0_tmra[15:12]))
		else $error("reserved pair reads nonzero");

	a_rsvd_write: assert property (
		s_wr(IDX_SER0_TMRA) |=> q_reg.ser0_tmra[11:10] == 2'h0)
		else $error("reserved pair took a write");

	a_dec0_field: assert property (
		s_wr(IDX_TMR_DEC0) && wb_sel_i[0]
		|=> q_reg.tmr_dec0 == $past(wb_dat_i[3:0]))
		else $error("decoder field not stored");

	a_tmr_write: assert property (
		s_wr(IDX_TMR_ABC) && wb_sel_i[1:0] == 2'h3
		|=> q_reg.tmr_abc == $past(wb_dat_i[15:0]))
		else $error("timer register write lost");

	a_lane_keep: assert property (
		s_wr(IDX_PWM_CONV) && !wb_sel_i[1]
		|=> q_reg.pwm_conv[15:8] == $past(q_reg.pwm_conv[15:8]))
		else $error("unselected lane changed");

	a_conv_byte: assert property (
		s_wr(IDX_PWM_CONV) && wb_sel_i[0]
		|=> q_reg.pwm_conv[7:0] == $past(wb_dat_i[7:0]))
		else $error("converter byte not stored");

	a_read_back: assert property (
		s_rd(IDX_PWM_CONV) |=> wb_dat_o == {16'h0000,
			$past(q_reg.pwm_conv)}
			&& q_reg.pwm_conv == $past(q_reg.pwm_conv))
		else $error("read data mismatch or read side effect");

	a_off_blocks: assert property (
		((lvl0_req_o | lvl1_req_o | lvl2_req_o)
			& ~$past(dif.en)) == '0)
		else $error("disabled source forwarded");

	a_one_level: assert property (
		((lvl0_req_o & lvl1_req_o) | (lvl0_req_o & lvl2_req_o)
			| (lvl1_req_o & lvl2_req_o)) == '0)
		else $error("source on two levels");

	a_top_level: assert property (
		lvl2_req_o[NSRC-1] == $past(src_req_i[NSRC-1]
			&& q_reg.pwm_conv[15:14] == CODE_LVL2))
		else $error("top source level mismatch");

	a_pwm_fault: assert property (
		src_req_i[NSRC-1] && q_reg.pwm_conv[15:14] == CODE_LVL0
		|=> lvl0_req_o[NSRC-1] && !lvl1_req_o[NSRC-1])
		else $error("pwm fault level wrong");

	a_serial_map: assert property (
		src_req_i[16] && q_reg.ser0_tmra[15:14] == CODE_LVL1
		|=> lvl1_req_o[16])
		else $error("serial rx full level wrong");

	sequence s_unmapped_rd;
		hit && !wb_we_i && !(aligned && idx >= IDX_TMR_DEC0
			&& idx <= IDX_PWM_CONV);
	endsequence

	a_unmapped_zero: assert property (
		s_unmapped_rd |=> wb_dat_o == '0)
		else $error("unmapped read not zero");

	a_wr_data_zero: assert property (
		hit && wb_we_i |=> wb_dat_o == '0)
		else $error("read data not cleared by write");

	a_dec0_upper: assert property (
		s_rd(IDX_TMR_DEC0) |=> wb_dat_o[DAT_W-1:DEC0_W] == '0)
		else $error("decoder register upper bits nonzero");

	a_ser0_write: assert property (
		s_wr(IDX_SER0_TMRA) && wb_sel_i[1:0] == 2'h3
		|=> q_reg.ser0_tmra
			== ($past(wb_dat_i[15:0]) & MASK_SER0_TMRA))
		else $error("serial register write lost");

	a_pwm_high: assert property (
		s_wr(IDX_PWM_CONV) && wb_sel_i[1]
		|=> q_reg.pwm_conv[15:8] == $past(wb_dat_i[15:8]))
		else $error("pwm byte not stored");

	a_wr_isolated: assert property (
		s_wr(IDX_TMR_ABC) |=> $stable(q_reg.tmr_dec0)
			&& $stable(q_reg.ser0_tmra) && $stable(q_reg.pwm_conv))
		else $error("timer write disturbed another register");

	a_idle_keep: assert property (
		!hit |=> $stable(q_reg.tmr_dec0) && $stable(q_reg.tmr_abc)
			&& $stable(q_reg.ser0_tmra) && $stable(q_reg.pwm_conv))
		else $error("field changed without a write");

	a_dec0_en: assert property (
		src_en_o[1:0] == {$past(q_reg.tmr_dec0[3:2]) != CODE_OFF,
			$past(q_reg.tmr_dec0[1:0]) != CODE_OFF})
		else $error("decoder enables wrong");

	a_lvl_needs_req: assert property (
		((lvl0_req_o | lvl1_req_o | lvl2_req_o) & ~$past(src_req_i))
			== '0)
		else $error("level raised without a request");

	a_any_level: assert property (
		lvl_any_o == {|lvl2_req_o, |lvl1_req_o, |lvl0_req_o})
		else $error("summary levels disagree");

	a_timer_a0: assert property (
		src_req_i[9] && q_reg.tmr_abc[15:14] == CODE_LVL2
		|=> lvl2_req_o[9] && !lvl0_req_o[9])
		else $error("timer A0 level wrong");

	a_dec0_index: assert property (
		src_req_i[1] && q_reg.tmr_dec0[3:2] == CODE_LVL1
		|=> lvl1_req_o[1])
		else $error("decoder index level wrong");

	a_conv_zero: assert property (
		src_req_i[20] && q_reg.pwm_conv[7:6] == CODE_LVL0
		|=> lvl0_req_o[20])
		else $error("converter zero-cross level wrong");

endmodule // ipl_regs

/* verification/ipl_core_model.sv */
// core-side model: reports the highest requested level
`timescale 1ns/100ps
module ipl_core_model
	import ipl_pkg::*;
(
	input wire logic [2:0] lvl_any_i,
	output logic [1:0] top_code_o
);
	always_comb begin
		if (lvl_any_i[2]) begin
			top_code_o = CODE_LVL2;
		end else if (lvl_any_i[1]) begin
			top_code_o = CODE_LVL1;
		end else if (lvl_any_i[0]) begin
			top_code_o = CODE_LVL0;
		end else begin
			top_code_o = CODE_OFF;
		end
	end
endmodule // ipl_core_model

/* verification/tb_irq_priority_level_regs.sv */
// self-checking bench for the priority-level register slice
`timescale 1ns/100ps
module tb_irq_priority_level_regs;
	import ipl_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [SEL_W-1:0] wb_sel_i = '0;
	logic [DAT_W-1:0] wb_dat_i = '0;
	logic [DAT_W-1:0] wb_dat_o;
	logic wb_ack_o;
	logic [NSRC-1:0] src_req_i = '0;
	logic [NSRC-1:0] src_en_o, lvl0_req_o, lvl1_req_o, lvl2_req_o;
	logic [2:0] lvl_any_o;
	logic [1:0] top_code;
	logic [31:0] q;
	logic [31:0] one;
	logic [7:0] adrs [4] = '{8'h18, 8'h1c, 8'h20, 8'h24};
	logic [15:0] msks [4] = '{16'h000f, 16'hffff, 16'hf3ff, 16'hffff};
	int error_cnt = 0;
	int checks_done = 0;
	always #2 clk_i = ~clk_i;

	ipl_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .src_req_i(src_req_i), .src_en_o(src_en_o),
		.lvl0_req_o(lvl0_req_o), .lvl1_req_o(lvl1_req_o),
		.lvl2_req_o(lvl2_req_o), .lvl_any_o(lvl_any_o));
	ipl_core_model core (.lvl_any_i(lvl_any_o), .top_code_o(top_code));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// request held until ack seen in its cycle, released at the ack edge
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(negedge clk_i);
			n++;
			if (n > 20) begin
				error_cnt++;
				end_sim();
			end
		end while (wb_ack_o !== 1'b1);
		@(posedge clk_i);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	// writes land at the taking edge, outputs follow one stage later
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, 4'hf, d);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 4'hf, 32'h0);
		chk(q, e);
	endtask
	task automatic rd_all(input logic [15:0] m);
		for (int i = 0; i < 4; i++) begin
			rd(adrs[i], {16'h0, msks[i] & m});
		end
	endtask
	// field position of source k, order as the source list
	function automatic int f_lsb(input int k);
		if (k < 2) return 2 * k;
		if (k < 10) return 2 * (k - 2);
		if (k < 15) return 2 * (k - 10);
		if (k < 17) return 2 * (k - 9);
		return 2 * (k - 17);
	endfunction
	function automatic int f_reg(input int k);
		return (k < 2) ? 0 : (k < 10) ? 1 : (k < 17) ? 2 : 3;
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_all(16'h0000);
		chk({29'h0, lvl_any_o}, 32'h0);
		$display("test reset values done");
		src_req_i <= '1;
		for (int k = 0; k < NSRC; k++) begin
			for (int c = 3; c >= 0; c--) begin
				one = 32'h1 << k;
				wr(adrs[f_reg(k)], c << f_lsb(k));
				chk(src_en_o, (c != 0) ? one : 32'h0);
				chk(lvl0_req_o, (c == 1) ? one : 32'h0);
				chk(lvl1_req_o, (c == 2) ? one : 32'h0);
				chk(lvl2_req_o, (c == 3) ? one : 32'h0);
				chk(top_code, c);
			end
		end
		$display("test field map done");
		for (int i = 0; i < 4; i++) begin
			wr(adrs[i], 32'hffff_ffff);
		end
		rd_all(16'hffff);
		rd_all(16'hffff);
		@(negedge clk_i);
		chk(lvl2_req_o, {NSRC{1'b1}});
		chk({29'h0, lvl_any_o}, 32'h4);
		@(posedge clk_i);
		src_req_i <= '0;
		repeat (2) @(negedge clk_i);
		chk(src_en_o, {NSRC{1'b1}});
		chk(lvl0_req_o, 32'h0);
		chk(lvl1_req_o, 32'h0);
		chk(lvl2_req_o, 32'h0);
		chk({29'h0, lvl_any_o}, 32'h0);
		$display("test full pattern done");
		wr(8'h1c, 32'h0);
		xfer(1'b1, 8'h1c, 4'h1, 32'hffff_ffff);
		xfer(1'b1, 8'h1c, 4'h2, 32'h0000_0000);
		rd(8'h1c, 32'h0000_00ff);
		xfer(1'b1, 8'h24, 4'h1, 32'h0000_00a5);
		rd(8'h24, 32'h0000_ffa5);
		wr(8'h28, 32'hffff);
		rd(8'h28, 32'h0);
		rd(8'h1d, 32'h0);
		$display("test byte lanes and unmapped done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_all(16'h0000);
		$display("test second reset done");
		end_sim();
	end
endmodule // tb_irq_priority_level_regs
